// ==== hdl/frs_sequencer.sv ====
`timescale 1ns/1ps
// Notes on behaviour
// - run pin or function write 05h starts torque control
// - run pin or function write 01h starts velocity control
// - torque mode: quadrature target from torque register, direct target zero
// - both current loops update once per pwm period
// - torque register writes take effect while running, no stop
// - pin low or start bit zero pauses; pin high or bit one resumes
// - torque mode pause clears both current-loop integrators
// - velocity mode: speed loop output feeds quadrature current target
// - speed loop runs once every N pwm periods, N from divider register
// - velocity mode: direct target from direct reference register, open loop
// - velocity mode pause clears speed and both current integrators
// - reset holds all control state and configuration at reset values
module frs_sequencer (
  // clock, reset, enable
  input wire logic core_clk_in,
  input wire logic rst_in,
  input wire logic clk_en_in,
  // run pin
  input wire logic run_switch_in,
  // register port from the serial deframer
  input wire logic reg_wr_in,
  input wire logic reg_rd_in,
  input wire logic [7:0] reg_addr_in,
  input wire logic [7:0] reg_wdata_in,
  output logic [7:0] reg_rdata_out,
  // speed loop result
  input wire logic [7:0] speed_loop_iq_in,
  // loop control outputs
  output logic running_out,
  output logic torque_mode_out,
  output logic current_loop_tick_out,
  output logic speed_loop_tick_out,
  output logic [7:0] quadrature_current_target_out,
  output logic [7:0] direct_current_target_out,
  output logic [7:0] velocity_ref_out,
  output logic current_integ_clear_out,
  output logic speed_integ_clear_out
);

  frs_tick_if tick_if ();

  frs_pwm_timer u_timer (
    .core_clk_in(core_clk_in),
    .rst_in(rst_in),
    .clk_en_in(clk_en_in),
    .tick_if(tick_if)
  );

  // write strobe for one offset; used for every writable register
  function automatic logic wr_hit(input logic wr, input logic [7:0] addr, input logic [7:0] ofs);
    wr_hit = wr && (addr == ofs);
  endfunction

  logic [7:0] speed_div_reg;
  logic [7:0] pwm_period_reg;
  logic [7:0] vel_stage_reg;
  logic [7:0] torque_ref_reg;
  logic [7:0] direct_ref_reg;
  logic [7:0] function_reg;
  logic vel_pending_reg;
  logic run_pin_prev_reg;
  logic run_cmd_reg;
  logic run_cmd_next;
  frs_pkg::frs_state_e state_reg;
  frs_pkg::frs_state_e state_next;
  logic mode_torque_next;
  logic [7:0] status_val;
  logic [7:0] rd_mux;
  logic fn_wr;
  logic vel_wr;
  logic pin_changed;
  logic start_evt;
  logic pause_evt;
  logic vel_take;

  ////////////////////////////////////////////////////////////////
  // run command arbitration
  assign fn_wr = wr_hit(reg_wr_in, reg_addr_in, frs_pkg::OFS_FUNCTION);
  assign vel_wr = wr_hit(reg_wr_in, reg_addr_in, frs_pkg::OFS_VEL_REF);
  assign pin_changed = (run_switch_in != run_pin_prev_reg);
  // a function write in the same cycle as a pin edge wins, being the host's newest word
  assign run_cmd_next = fn_wr ? reg_wdata_in[frs_pkg::FN_START_BIT] :
                        (pin_changed ? run_switch_in : run_cmd_reg);

  ////////////////////////////////////////////////////////////////
  // state transitions; the start bit and pin are expected low during setup
  assign start_evt = run_cmd_next && (state_reg != frs_pkg::ST_RUN);
  assign pause_evt = !run_cmd_next && (state_reg == frs_pkg::ST_RUN);
  assign mode_torque_next = fn_wr ? reg_wdata_in[frs_pkg::FN_TORQUE_BIT] :
                            function_reg[frs_pkg::FN_TORQUE_BIT];

  always_comb
  begin
    state_next = state_reg;
    case (state_reg)
      frs_pkg::ST_IDLE:
        if (start_evt)
          state_next = frs_pkg::ST_RUN;
      frs_pkg::ST_RUN:
        if (pause_evt)
          state_next = frs_pkg::ST_PAUSE;
      frs_pkg::ST_PAUSE:
        if (start_evt)
          state_next = frs_pkg::ST_RUN;
      default:
        state_next = frs_pkg::ST_IDLE;
    endcase
  end

  ////////////////////////////////////////////////////////////////
  // timer control
  assign tick_if.enable = (state_reg == frs_pkg::ST_RUN);
  assign tick_if.period = pwm_period_reg;
  assign tick_if.divider = speed_div_reg;

  // staged velocity reference moves in at a speed step, or at once when not running
  assign vel_take = vel_pending_reg && (tick_if.speed_tick || (state_reg != frs_pkg::ST_RUN));

  ////////////////////////////////////////////////////////////////
  // status and read mux
  assign status_val = {3'h0, !vel_pending_reg, 1'b0, torque_mode_out, 1'b0, running_out};
  assign rd_mux = (reg_addr_in == frs_pkg::OFS_SPEED_DIV) ? speed_div_reg :
                  (reg_addr_in == frs_pkg::OFS_PWM_PERIOD) ? pwm_period_reg :
                  (reg_addr_in == frs_pkg::OFS_VEL_REF) ? velocity_ref_out :
                  (reg_addr_in == frs_pkg::OFS_TORQUE_REF) ? torque_ref_reg :
                  (reg_addr_in == frs_pkg::OFS_DIRECT_REF) ? direct_ref_reg :
                  (reg_addr_in == frs_pkg::OFS_FUNCTION) ? function_reg :
                  (reg_addr_in == frs_pkg::OFS_STATUS) ? status_val : 8'h00;

  assign current_loop_tick_out = tick_if.pwm_tick;

  ////////////////////////////////////////////////////////////////
  // configuration registers; reset clears the references and function, sets divider to 01h and period to ffh
  always_ff @(posedge core_clk_in or posedge rst_in)
  begin
    if (rst_in)
    begin
      speed_div_reg <= frs_pkg::RST_SPEED_DIV;
      pwm_period_reg <= frs_pkg::RST_PWM_PERIOD;
      vel_stage_reg <= frs_pkg::RST_REF;
      torque_ref_reg <= frs_pkg::RST_REF;
      direct_ref_reg <= frs_pkg::RST_REF;
      function_reg <= frs_pkg::RST_FUNCTION;
    end
    else if (clk_en_in)
    begin
      if (wr_hit(reg_wr_in, reg_addr_in, frs_pkg::OFS_SPEED_DIV))
        speed_div_reg <= reg_wdata_in;
      if (wr_hit(reg_wr_in, reg_addr_in, frs_pkg::OFS_PWM_PERIOD))
        pwm_period_reg <= reg_wdata_in;
      if (vel_wr)
        vel_stage_reg <= reg_wdata_in;
      if (wr_hit(reg_wr_in, reg_addr_in, frs_pkg::OFS_TORQUE_REF))
        torque_ref_reg <= reg_wdata_in;
      if (wr_hit(reg_wr_in, reg_addr_in, frs_pkg::OFS_DIRECT_REF))
        direct_ref_reg <= reg_wdata_in;
      if (fn_wr)
        function_reg <= reg_wdata_in;
    end
  end

  ////////////////////////////////////////////////////////////////
  // sequencer state and run command
  always_ff @(posedge core_clk_in or posedge rst_in)
  begin
    if (rst_in)
    begin
      state_reg <= frs_pkg::ST_IDLE;
      run_cmd_reg <= 1'b0;
      run_pin_prev_reg <= 1'b0;
      running_out <= 1'b0;
      torque_mode_out <= 1'b0;
    end
    else if (clk_en_in)
    begin
      state_reg <= state_next;
      run_cmd_reg <= run_cmd_next;
      run_pin_prev_reg <= run_switch_in;
      running_out <= (state_next == frs_pkg::ST_RUN);
      if (start_evt)
        torque_mode_out <= mode_torque_next;
    end
  end

  ////////////////////////////////////////////////////////////////
  // velocity reference hand-off; a new write re-arms pending over a take
  always_ff @(posedge core_clk_in or posedge rst_in)
  begin
    if (rst_in)
    begin
      vel_pending_reg <= 1'b0;
      velocity_ref_out <= frs_pkg::RST_REF;
    end
    else if (clk_en_in)
    begin
      vel_pending_reg <= vel_wr || (vel_pending_reg && !vel_take);
      if (vel_take)
        velocity_ref_out <= vel_stage_reg;
    end
  end

  ////////////////////////////////////////////////////////////////
  // loop references and integrator clears
  always_ff @(posedge core_clk_in or posedge rst_in)
  begin
    if (rst_in)
    begin
      quadrature_current_target_out <= frs_pkg::RST_REF;
      direct_current_target_out <= frs_pkg::RST_REF;
      current_integ_clear_out <= 1'b0;
      speed_integ_clear_out <= 1'b0;
      speed_loop_tick_out <= 1'b0;
      reg_rdata_out <= 8'h00;
    end
    else if (clk_en_in)
    begin
      // torque mode forces direct target to zero for maximum torque per amp
      quadrature_current_target_out <= torque_mode_out ? torque_ref_reg : speed_loop_iq_in;
      direct_current_target_out <= torque_mode_out ? 8'h00 : direct_ref_reg;
      current_integ_clear_out <= pause_evt;
      speed_integ_clear_out <= pause_evt && !torque_mode_out;
      // a start in this cycle may flip the mode, so a stale tick is dropped
      speed_loop_tick_out <= tick_if.speed_tick && !torque_mode_out && !start_evt;
      if (reg_rd_in)
        reg_rdata_out <= rd_mux;
    end
  end

endmodule

// ==== hdl/frs_pkg.sv ====
package frs_pkg;
  // register offsets (byte wide register port)
  localparam logic [7:0] OFS_SPEED_DIV = 8'h01;
  localparam logic [7:0] OFS_PWM_PERIOD = 8'h11;
  localparam logic [7:0] OFS_VEL_REF = 8'h14;
  localparam logic [7:0] OFS_TORQUE_REF = 8'h15;
  localparam logic [7:0] OFS_DIRECT_REF = 8'h16;
  localparam logic [7:0] OFS_FUNCTION = 8'h17;
  localparam logic [7:0] OFS_STATUS = 8'h18;
  // function_control fields
  localparam int FN_START_BIT = 0;
  localparam int FN_TORQUE_BIT = 2;
  // controller_status fields
  localparam int ST_RUNNING_BIT = 0;
  localparam int ST_TORQUE_BIT = 2;
  localparam int ST_VEL_READY_BIT = 4;
  // reset values
  localparam logic [7:0] RST_SPEED_DIV = 8'h01;
  localparam logic [7:0] RST_PWM_PERIOD = 8'hff;
  localparam logic [7:0] RST_REF = 8'h00;
  localparam logic [7:0] RST_FUNCTION = 8'h00;
  // timing: one pwm period lasts (pwm_period + 1) core clocks
  localparam logic [7:0] PERIOD_ONE = 8'h01;
  // sequencer states
  typedef enum logic [1:0] {ST_IDLE, ST_RUN, ST_PAUSE} frs_state_e;
endpackage

// ==== hdl/frs_tick_if.sv ====
`timescale 1ns/1ps
interface frs_tick_if;
  logic enable;
  logic [7:0] period;
  logic [7:0] divider;
  logic pwm_tick;
  logic speed_tick;
  modport seq (output enable, output period, output divider, input pwm_tick, input speed_tick);
  modport timer (input enable, input period, input divider, output pwm_tick, output speed_tick);
endinterface

// ==== hdl/frs_pwm_timer.sv ====
`timescale 1ns/1ps
module frs_pwm_timer (
  // clock and reset
  input wire logic core_clk_in,
  input wire logic rst_in,
  input wire logic clk_en_in,
  // ticks toward the sequencer
  frs_tick_if.timer tick_if
);

  logic [7:0] cyc_reg;
  logic [7:0] cyc_next;
  logic [7:0] per_reg;
  logic [7:0] per_next;
  logic period_end;
  logic speed_end;

  ////////////////////////////////////////////////////////////////
  // period and speed-step decode; a divider of zero acts as one
  assign period_end = (cyc_reg == tick_if.period);
  assign speed_end = period_end && ((per_reg + frs_pkg::PERIOD_ONE) >= tick_if.divider);
  assign cyc_next = !tick_if.enable ? 8'h00 : (period_end ? 8'h00 : cyc_reg + frs_pkg::PERIOD_ONE);
  assign per_next = (!tick_if.enable || speed_end) ? 8'h00 : (period_end ? per_reg + frs_pkg::PERIOD_ONE : per_reg);

  ////////////////////////////////////////////////////////////////
  // counters restart while stopped so each run starts on a full period
  always_ff @(posedge core_clk_in or posedge rst_in)
  begin
    if (rst_in)
    begin
      cyc_reg <= 8'h00;
      per_reg <= 8'h00;
      tick_if.pwm_tick <= 1'b0;
      tick_if.speed_tick <= 1'b0;
    end
    else if (clk_en_in)
    begin
      cyc_reg <= cyc_next;
      per_reg <= per_next;
      tick_if.pwm_tick <= tick_if.enable && period_end;
      tick_if.speed_tick <= tick_if.enable && speed_end;
    end
  end

endmodule

// ==== sim/frs_sequencer_assertions.sv ====
`timescale 1ns/1ps
// port-level timing checks for the sequencer
module frs_sequencer_assertions (
  // clock and reset
  input wire logic core_clk_in,
  input wire logic rst_in,
  // host side
  input wire logic clk_en_in,
  input wire logic run_switch_in,
  input wire logic reg_wr_in,
  input wire logic [7:0] reg_addr_in,
  input wire logic [7:0] reg_wdata_in,
  // loop control
  input wire logic running_out,
  input wire logic torque_mode_out,
  input wire logic current_loop_tick_out,
  input wire logic speed_loop_tick_out,
  input wire logic [7:0] direct_current_target_out,
  input wire logic current_integ_clear_out,
  input wire logic speed_integ_clear_out
);
  default clocking @(posedge core_clk_in); endclocking
  default disable iff (rst_in);
  // only starts from stop count, a start while running is refused
  wire fn_start = clk_en_in && reg_wr_in && reg_addr_in == frs_pkg::OFS_FUNCTION && !running_out;
  wire pin_only = clk_en_in && !reg_wr_in;
  ////////////////////////////////////////////////////////////////////////////////
  torque_start_a: assert property (fn_start && reg_wdata_in == 8'h05 |=> running_out && torque_mode_out)
    else $error("torque start missed");
  vel_start_a: assert property (fn_start && reg_wdata_in == 8'h01 |=> running_out && !torque_mode_out)
    else $error("velocity start missed");
  pin_start_a: assert property (pin_only && !running_out && $rose(run_switch_in) |=> running_out)
    else $error("pin start missed");
  pin_pause_a: assert property (pin_only && running_out && $fell(run_switch_in) |=> !running_out)
    else $error("pin pause missed");
  pause_clear_a: assert property ($fell(running_out) |-> current_integ_clear_out)
    else $error("current clear missing");
  speed_clear_a: assert property ($fell(running_out) && !torque_mode_out |-> speed_integ_clear_out)
    else $error("speed clear missing");
  clear_pulse_a: assert property (current_integ_clear_out |=> !current_integ_clear_out)
    else $error("clear longer than one cycle");
  speed_mode_a: assert property (speed_loop_tick_out || speed_integ_clear_out |-> !torque_mode_out)
    else $error("speed activity in torque mode");
  direct_zero_a: assert property (running_out && torque_mode_out ##1 running_out && torque_mode_out
    |-> direct_current_target_out == 8'h00) else $error("direct target not zero");
  tick_run_a: assert property (current_loop_tick_out |-> running_out || $past(running_out))
    else $error("tick while stopped");
endmodule
bind frs_sequencer frs_sequencer_assertions chk_u (.core_clk_in, .rst_in, .clk_en_in, .run_switch_in, .reg_wr_in,
  .reg_addr_in, .reg_wdata_in, .running_out, .torque_mode_out, .current_loop_tick_out, .speed_loop_tick_out,
  .direct_current_target_out, .current_integ_clear_out, .speed_integ_clear_out);

// ==== sim/frs_host_model.sv ====
`timescale 1ns/1ps
// host processor: register port and run pin
module frs_host_model (
  // clock
  input wire logic core_clk_in,
  // register port
  output logic reg_wr_out,
  output logic reg_rd_out,
  output logic [7:0] reg_addr_out,
  output logic [7:0] reg_wdata_out,
  input wire logic [7:0] reg_rdata_in,
  // run pin
  output logic run_out
);
  // pin and start bit low until configuration is done
  initial {reg_wr_out, reg_rd_out, reg_addr_out, reg_wdata_out, run_out} = '0;
  ////////////////////////////////////////////////////////////////////////////////
  // released lines flip so a stale value is never mistaken for a live one
  task wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge core_clk_in) #1;
    {reg_wr_out, reg_addr_out, reg_wdata_out} = {1'b1, a, d};
    @(posedge core_clk_in) #1;
    {reg_wr_out, reg_addr_out, reg_wdata_out} = {1'b0, ~a, ~d};
  endtask
  task rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge core_clk_in) #1;
    {reg_rd_out, reg_addr_out} = {1'b1, a};
    @(posedge core_clk_in) #1;
    {reg_rd_out, reg_addr_out} = {1'b0, ~a};
    d = reg_rdata_in;
  endtask
  // velocity reference goes in once the ready bit is up, or after 64 status reads without it
  task vel_wr(input logic [7:0] d);
    logic [7:0] s;
    s = 8'h00;
    for (int i = 0; i < 64 && !s[frs_pkg::ST_VEL_READY_BIT]; i++) rd(frs_pkg::OFS_STATUS, s);
    wr(frs_pkg::OFS_VEL_REF, d);
  endtask
  task pin(input logic v);
    @(posedge core_clk_in) #1;
    run_out = v;
  endtask
endmodule

// ==== sim/testbench.sv ====
`timescale 1ns/1ps
module testbench;
  // stimulus, design outputs and tallies
  logic core_clk_in = 0;
  logic rst_in = 1;
  logic clk_en_in = 1;
  logic [7:0] speed_loop_iq_in = 8'h44;
  wire reg_wr_in, reg_rd_in, run_switch_in, running_out, torque_mode_out, current_loop_tick_out;
  wire speed_loop_tick_out, current_integ_clear_out, speed_integ_clear_out;
  wire [7:0] reg_addr_in, reg_wdata_in, reg_rdata_out, quadrature_current_target_out, direct_current_target_out;
  wire [7:0] velocity_ref_out;
  int error_cnt = 0;
  int checks_done = 0;
  int cyc = 0, last = 0, gap = 0, ccnt = 0, scnt = 0, cclr = 0, sclr = 0, s, n, m;
  logic [7:0] d;
  frs_sequencer dut_u (.core_clk_in(core_clk_in), .rst_in(rst_in), .clk_en_in(clk_en_in), .run_switch_in(run_switch_in),
    .reg_wr_in(reg_wr_in), .reg_rd_in(reg_rd_in), .reg_addr_in(reg_addr_in), .reg_wdata_in(reg_wdata_in),
    .reg_rdata_out(reg_rdata_out), .speed_loop_iq_in(speed_loop_iq_in), .running_out(running_out),
    .torque_mode_out(torque_mode_out), .current_loop_tick_out(current_loop_tick_out),
    .speed_loop_tick_out(speed_loop_tick_out), .quadrature_current_target_out(quadrature_current_target_out),
    .direct_current_target_out(direct_current_target_out), .velocity_ref_out(velocity_ref_out),
    .current_integ_clear_out(current_integ_clear_out), .speed_integ_clear_out(speed_integ_clear_out));
  frs_host_model host_u (.core_clk_in, .reg_wr_out(reg_wr_in), .reg_rd_out(reg_rd_in), .reg_addr_out(reg_addr_in),
    .reg_wdata_out(reg_wdata_in), .reg_rdata_in(reg_rdata_out), .run_out(run_switch_in));
  always #20 core_clk_in = ~core_clk_in;
  // counted at the edge so one-cycle pulses are never missed
  always @(posedge core_clk_in)
  begin
    cyc <= cyc + 1;
    if (current_loop_tick_out === 1'b1)
    begin
      gap <= cyc - last;
      last <= cyc;
    end
    ccnt <= ccnt + (current_loop_tick_out === 1'b1);
    scnt <= scnt + (speed_loop_tick_out === 1'b1);
    cclr <= cclr + (current_integ_clear_out === 1'b1);
    sclr <= sclr + (speed_integ_clear_out === 1'b1);
  end
  ////////////////////////////////////////////////////////////////////////////////
  task chk(input logic [7:0] got, input logic [7:0] exp);
    checks_done++;
    if (got !== exp)
    begin
      error_cnt++;
      $display("[ERR] %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task step(input int k);
    repeat (k) @(posedge core_clk_in);
    #1;
  endtask
  task rchk(input logic [7:0] a, input logic [7:0] e);
    host_u.rd(a, d);
    chk(d, e);
  endtask
  task wait_speed();
    s = scnt;
    for (int i = 0; i < 99 && scnt == s; i++) step(1);
  endtask
  task wrap_up();
    if (error_cnt == 0 && checks_done > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  // reset values, an unmapped place and a read-only one
  task t_regs();
    rchk(8'h01, frs_pkg::RST_SPEED_DIV);
    rchk(8'h11, frs_pkg::RST_PWM_PERIOD);
    rchk(8'h16, frs_pkg::RST_REF);
    rchk(8'h17, frs_pkg::RST_FUNCTION);
    host_u.wr(8'h30, 8'h5c);
    host_u.wr(8'h18, 8'h5c);
    rchk(8'h18, 8'h10);
    rchk(8'h30, 8'h00);
    chk({7'h0, running_out}, 8'h00);
  endtask
  // torque run: targets, tick spacing, live update, pause and resume
  task t_torque();
    host_u.wr(8'h11, 8'h03);
    host_u.wr(8'h15, 8'h5a);
    host_u.wr(8'h17, 8'h05);
    step(12);
    chk({6'h0, running_out, torque_mode_out}, 8'h03);
    chk(gap[7:0], 8'h04);
    chk(quadrature_current_target_out, 8'h5a);
    chk(direct_current_target_out, 8'h00);
    rchk(8'h18, 8'h15);
    host_u.wr(8'h15, 8'h33);
    step(1);
    chk({running_out, quadrature_current_target_out[6:0]}, 8'hb3);
    {n, m} = {cclr, sclr};
    host_u.wr(8'h17, 8'h04);
    step(2);
    chk({running_out, 7'(cclr - n)}, 8'h01);
    chk(8'(sclr - m), 8'h00);
    host_u.wr(8'h17, 8'h05);
    step(1);
    chk({7'h0, running_out}, 8'h01);
    host_u.wr(8'h17, 8'h00);
  endtask
  // velocity run: divider, field weakening, reference handoff, pin control
  task t_vel();
    host_u.wr(8'h16, 8'h21);
    host_u.wr(8'h01, 8'h02);
    host_u.wr(8'h17, 8'h01);
    step(2);
    chk({6'h0, running_out, torque_mode_out}, 8'h02);
    chk(direct_current_target_out, 8'h21);
    chk(quadrature_current_target_out, 8'h44);
    wait_speed();
    n = ccnt;
    wait_speed();
    chk(8'(ccnt - n), 8'h02);
    host_u.vel_wr(8'h77);
    for (int i = 0; i < 99 && velocity_ref_out !== 8'h77; i++) step(1);
    chk(velocity_ref_out, 8'h77);
    host_u.pin(1'b1);
    {n, m} = {cclr, sclr};
    host_u.pin(1'b0);
    step(2);
    chk({running_out, 3'(cclr - n), 4'(sclr - m)}, 8'h11);
    host_u.pin(1'b1);
    step(2);
    chk({6'h0, running_out, torque_mode_out}, 8'h02);
    host_u.wr(8'h17, 8'h00);
    step(1);
    chk({7'h0, running_out}, 8'h00);
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  initial
  begin
    step(12);
    rst_in = 0;
    t_regs();
    t_torque();
    t_vel();
    wrap_up();
  end
  // hang guard, far beyond the hundred or so cycles the tests need
  initial
  begin
    #400000;
    error_cnt++;
    wrap_up();
  end
endmodule
